// ---- tb/midi_keyboard_model.sv ----
/*
 * Keyboard model: sends one parsed MIDI message per call, one cycle long.
 * Assumes the block samples midiIn on the rising edge of clock.
 */
`timescale 1ns/10ps

module midi_keyboard_model
    import midi_map_pkg::*;
(
    input wire logic clock,
    output midiMsg_s midiOut
);
    // ==========================================================
    // idle line at start
    initial
    begin
        midiOut = '0;
    end

    // one message held over one edge, then released with data inverted
    task sendMsg(input msgKind_e kind, input logic [3:0] chan, input logic [6:0] d1, input logic [6:0] d2);
        @(posedge clock);
        #2;
        midiOut = '{kind, chan, d1, d2};
        @(posedge clock);
        #2;
        midiOut = '{MSG_NONE, ~chan, ~d1, ~d2};
    endtask : sendMsg

    // bank message on controller 32
    task bankSelect(input logic [3:0] chan, input logic [6:0] bank);
        sendMsg(MSG_CTRL, chan, CC_BANK_LSB, bank);
    endtask : bankSelect
endmodule : midi_keyboard_model

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the program map and step entry block.
 * Assumes the keyboard model drives midiIn; the bench drives the rest.
 */
`timescale 1ns/10ps

module tb;
    import midi_map_pkg::*;

    // ==========================================================
    // signals
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    midiMsg_s midiIn;
    pcFilter_e pcFilter = PC_ENABLED;
    stepMode_e stepMode = STEP_FULL;
    logic memProtect = 1'h0;
    logic [6:0] patternSel = 7'h03;
    logic [6:0] stepCount = 7'h04;
    logic stepSelValid = 1'h0;
    logic [5:0] stepSelIdx = 6'h00;
    stepEdit_s stepEdit = '0;
    mapEdit_s mapEdit = '0;
    logic mapWriteCmd = 1'h0;
    logic patternWriteCmd = 1'h0;
    loadReq_s loadReq;
    logic [5:0] curStep;
    step_s stepView;
    patStore_s patternStore;
    logic mapStored;
    int failures = 0;
    int checksDone = 0;
    logic seen;

    typedef struct {
        pcFilter_e f;
        logic bankOn;
        logic [6:0] bank;
        logic [3:0] ch;
        logic [6:0] prog;
        logic expValid;
        logic expMap;
        logic expAssign;
        mapEntry_s expEntry;
        logic [6:0] expBank;
    } pcRow_s;

    // program change cases: filter, bank, part, program, expected load
    pcRow_s rows [8] = '{
        '{PC_ENABLED, 1'h0, 7'h00, 4'h1, 7'h05, 1'h1, 1'h1, 1'h0, '{TGT_PERF_A, 7'h0A}, 7'h00},
        '{PC_ENABLED, 1'h1, 7'h03, 4'h1, 7'h07, 1'h1, 1'h0, 1'h0, '{TGT_CURR, 7'h07}, 7'h03},
        '{PC_ENABLED, 1'h0, 7'h00, 4'h1, 7'h08, 1'h1, 1'h0, 1'h0, '{TGT_CURR, 7'h08}, 7'h03},
        '{PC_ENABLED, 1'h1, 7'h00, 4'h1, 7'h09, 1'h1, 1'h1, 1'h1, '{TGT_ARP_USER, 7'h14}, 7'h00},
        '{PC_FORCE_MAP, 1'h1, 7'h03, 4'h1, 7'h05, 1'h1, 1'h1, 1'h0, '{TGT_PERF_A, 7'h0A}, 7'h00},
        '{PC_DISABLED, 1'h1, 7'h02, 4'h4, 7'h05, 1'h0, 1'h0, 1'h0, '{TGT_CURR, 7'h00}, 7'h00},
        '{PC_ENABLED, 1'h0, 7'h00, 4'h4, 7'h05, 1'h1, 1'h1, 1'h0, '{TGT_PERF_A, 7'h0A}, 7'h00},
        '{PC_ENABLED, 1'h0, 7'h00, 4'h6, 7'h00, 1'h1, 1'h1, 1'h0, '{TGT_CURR, 7'h00}, 7'h00}
    };

    // ==========================================================
    // clock, keyboard and block under test
    always #12.5 clock = ~clock;

    midi_keyboard_model kb (.clock(clock), .midiOut(midiIn));

    midi_program_map_and_step_entry midi_program_map_and_step_entry_i (
        .clock(clock),
        .arst_n(arst_n),
        .midiIn(midiIn),
        .pcFilter(pcFilter),
        .stepMode(stepMode),
        .memProtect(memProtect),
        .patternSel(patternSel),
        .stepCount(stepCount),
        .stepSelValid(stepSelValid),
        .stepSelIdx(stepSelIdx),
        .stepEdit(stepEdit),
        .mapEdit(mapEdit),
        .mapWriteCmd(mapWriteCmd),
        .patternWriteCmd(patternWriteCmd),
        .loadReq(loadReq),
        .curStep(curStep),
        .stepView(stepView),
        .patternStore(patternStore),
        .mapStored(mapStored)
    );

    // ==========================================================
    // helpers
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    // bounded poll of a one-cycle pulse
    task waitFor(input logic [1:0] which, input logic must, output logic got);
        got = 1'h0;
        for (int n = 0; n < 4 && got !== 1'h1; n++)
        begin
            got = which == 2'h0 ? loadReq.valid : which == 2'h1 ? mapStored : patternStore.valid;
            if (got !== 1'h1)
            begin
                @(posedge clock);
                #2;
            end
        end
        if (must && got !== 1'h1)
        begin
            failures++;
            $display("ERROR at %0t: wait ran out", $time);
            conclude();
        end
    endtask : waitFor

    task play(input msgKind_e kind, input logic [6:0] d1, input logic [6:0] d2);
        kb.sendMsg(kind, d1[3:0], d1, d2);
        repeat (2) @(posedge clock);
        #2;
    endtask : play

    task selStep(input logic [5:0] idx);
        stepSelIdx = idx;
        stepSelValid = 1'h1;
        @(posedge clock);
        #2;
        stepSelValid = 1'h0;
        @(posedge clock);
        #2;
    endtask : selStep

    // one panel field edit, then a quiet cycle
    task editStep(input editField_e f, input logic [6:0] v);
        stepEdit = '{1'h1, f, v};
        @(posedge clock);
        #2;
        stepEdit = '0;
        @(posedge clock);
        #2;
    endtask : editStep

    task writeMap(input logic [6:0] idx, input mapEntry_s e, input logic prot);
        memProtect = prot;
        mapEdit = '{1'h1, idx, e};
        @(posedge clock);
        #2;
        mapEdit = '0;
        mapWriteCmd = 1'h1;
        @(posedge clock);
        #2;
        mapWriteCmd = 1'h0;
        waitFor(2'h1, ~prot, seen);
        check(seen, !prot, "map store pulse");
        memProtect = 1'h0;
    endtask : writeMap

    task storePattern(input logic [6:0] pat, input logic prot);
        memProtect = prot;
        patternSel = pat;
        patternWriteCmd = 1'h1;
        @(posedge clock);
        #2;
        patternWriteCmd = 1'h0;
        waitFor(2'h2, ~prot, seen);
        check(seen, !prot, "pattern store pulse");
        if (seen === 1'h1)
            check({patternStore.pattern, patternStore.poly, patternStore.count}, {pat, pat > 7'h3F, 7'h04}, "store");
        memProtect = 1'h0;
    endtask : storePattern

    task conclude();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        #2;
        arst_n = 1'h1;
        check({loadReq.valid, mapStored, patternStore.valid, curStep, stepView}, 32'h0, "reset outputs");
        $display("test reset done");
        writeMap(7'h05, '{TGT_PERF_A, 7'h0A}, 1'h0);
        writeMap(7'h05, '{TGT_PROG_B, 7'h01}, 1'h1);
        writeMap(7'h09, '{TGT_ARP_USER, 7'h14}, 1'h0);
        $display("test map write done");
        // table of program change cases
        foreach (rows[i])
        begin
            pcFilter = rows[i].f;
            if (rows[i].bankOn)
                kb.bankSelect(rows[i].ch, rows[i].bank);
            kb.sendMsg(MSG_PROG, rows[i].ch, rows[i].prog, 7'h00);
            waitFor(2'h0, rows[i].expValid, seen);
            check(seen, rows[i].expValid, "load pulse");
            if (seen === 1'h1)
            begin
                check({loadReq.part, loadReq.viaMap, loadReq.assignPattern, loadReq.entry},
                      {rows[i].ch, rows[i].expMap, rows[i].expAssign, rows[i].expEntry}, "load");
                if (!rows[i].expMap)
                    check(loadReq.bank, rows[i].expBank, "bank");
            end
        end
        $display("test program change done");
        // step entry on a mono pattern of four steps
        play(MSG_NOTE_ON, 7'h3E, 7'h64);
        check(stepView, {GATE_NORM, 7'h03, 7'h64}, "note on");
        play(MSG_NOTE_OFF, 7'h3E, 7'h40);
        check(curStep, 6'h01, "note off");
        play(MSG_CTRL, CC_SUSTAIN, 7'h7F);
        check(stepView.gate, GATE_REST, "rest");
        play(MSG_CTRL, CC_SUSTAIN, 7'h00);
        check(curStep, 6'h02, "pedal up");
        play(MSG_CTRL, CC_SUSTAIN, 7'h7F);
        play(MSG_NOTE_ON, 7'h40, 7'h5A);
        check(stepView.gate, GATE_TIE, "tie");
        play(MSG_NOTE_OFF, 7'h40, 7'h40);
        play(MSG_CTRL, CC_SUSTAIN, 7'h00);
        check(curStep, 6'h03, "tie advance");
        play(MSG_NOTE_ON, 7'h41, 7'h50);
        play(MSG_CTRL, CC_SUSTAIN, 7'h7F);
        check(stepView.gate, GATE_GLIDE, "glide");
        play(MSG_NOTE_OFF, 7'h41, 7'h40);
        check(curStep, 6'h00, "wrap");
        play(MSG_CTRL, CC_SUSTAIN, 7'h00);
        selStep(6'h3F);
        check(curStep, 6'h03, "clamp");
        selStep(6'h00);
        stepMode = STEP_OFF;
        play(MSG_NOTE_ON, 7'h30, 7'h10);
        play(MSG_NOTE_OFF, 7'h30, 7'h40);
        check({stepView, curStep}, {GATE_NORM, 7'h03, 7'h64, 6'h00}, "off");
        $display("test mono step entry done");
        // poly pattern: clamped and signed transpose
        stepMode = STEP_FULL;
        patternSel = 7'h46;
        play(MSG_NOTE_ON, 7'h0A, 7'h05);
        check(stepView, {GATE_NORM, 7'h5C, 7'h05}, "poly clamp");
        play(MSG_NOTE_OFF, 7'h0A, 7'h40);
        selStep(6'h00);
        play(MSG_NOTE_ON, 7'h32, 7'h7F);
        check(stepView, {GATE_NORM, 7'h76, 7'h7F}, "poly note");
        play(MSG_NOTE_OFF, 7'h32, 7'h40);
        $display("test poly step entry done");
        // note and velocity edits on a tie step are refused, a glide step takes them
        editStep(EDIT_GATE, 7'h01);
        editStep(EDIT_NOTE, 7'h05);
        editStep(EDIT_VEL, 7'h09);
        check(stepView, {GATE_TIE, 7'h00, 7'h00}, "tie edit refused");
        editStep(EDIT_GATE, 7'h03);
        editStep(EDIT_NOTE, 7'h7F);
        editStep(EDIT_VEL, 7'h00);
        check(stepView, {GATE_GLIDE, 7'h7F, 7'h01}, "glide edit");
        // single-field keyboard modes on steps 1 to 3
        stepMode = STEP_GATE;
        play(MSG_NOTE_ON, 7'h3C, 7'h20);
        check(stepView, {GATE_NORM, 7'h7F, 7'h01}, "gate only");
        play(MSG_NOTE_OFF, 7'h3C, 7'h40);
        stepMode = STEP_NOTE;
        play(MSG_NOTE_ON, 7'h3D, 7'h20);
        check(stepView, {GATE_TIE, 7'h01, 7'h00}, "note only");
        play(MSG_NOTE_OFF, 7'h3D, 7'h40);
        stepMode = STEP_VEL;
        play(MSG_NOTE_ON, 7'h3C, 7'h20);
        check(stepView, {GATE_GLIDE, 7'h06, 7'h20}, "velocity only");
        play(MSG_NOTE_OFF, 7'h3C, 7'h40);
        check(curStep, 6'h00, "single field advance");
        stepMode = STEP_FULL;
        $display("test panel edit done");
        storePattern(7'h3F, 1'h1);
        storePattern(7'h3F, 1'h0);
        storePattern(7'h40, 1'h0);
        $display("test pattern store done");
        // reset in mid-run brings the map back for part 1
        @(posedge clock);
        #2;
        arst_n = 1'h0;
        @(posedge clock);
        #2;
        arst_n = 1'h1;
        check({curStep, stepView}, 32'h0, "second reset");
        kb.sendMsg(MSG_PROG, 4'h1, 7'h08, 7'h00);
        waitFor(2'h0, 1'h1, seen);
        check({loadReq.viaMap, loadReq.entry}, {1'h1, TGT_CURR, 7'h00}, "mapped after reset");
        $display("test second reset done");
        conclude();
    end
endmodule : tb

// ---- verilog/midi_map_pkg.sv ----
/*
 * Shared types and constants for the MIDI program map and step entry block.
 * Assumes MIDI bytes are already parsed into whole messages on the same clock.
 */
package midi_map_pkg;

    // ==========================================================
    // message and controller encodings
    localparam logic [6:0] CC_BANK_MSB = 7'h00;
    localparam logic [6:0] CC_BANK_LSB = 7'h20;
    localparam logic [6:0] CC_SUSTAIN = 7'h40;
    localparam logic [6:0] SUSTAIN_ON_MIN = 7'h40;
    localparam logic [6:0] MAP_BANK = 7'h00;

    // ==========================================================
    // pattern limits
    localparam logic [6:0] MONO_LAST = 7'h3F;
    localparam logic [6:0] STEP_COUNT_MIN = 7'h01;
    localparam logic [6:0] STEP_COUNT_MAX = 7'h40;
    localparam logic [5:0] STEP_LAST_MAX = 6'h3F;
    localparam logic signed [7:0] MONO_NOTE_MIN = 8'sh01;
    localparam logic signed [7:0] MONO_NOTE_MAX = 8'sh0C;
    localparam logic signed [7:0] POLY_NOTE_MIN = 8'shDC;
    localparam logic signed [7:0] POLY_NOTE_MAX = 8'sh24;
    localparam logic [6:0] KEYS_PER_OCTAVE = 7'h0C;
    localparam logic [7:0] NOTE_REF = 8'h3C;
    localparam logic [6:0] VEL_MIN = 7'h01;

    // ==========================================================
    // reset values
    localparam logic [6:0] BANK_RST = 7'h00;
    localparam logic [5:0] PTR_RST = 6'h00;

    // ==========================================================
    // modes and encodings
    typedef enum logic [1:0] {PC_ENABLED, PC_FORCE_MAP, PC_DISABLED} pcFilter_e;
    typedef enum logic [2:0] {STEP_OFF, STEP_FULL, STEP_NOTE, STEP_VEL, STEP_GATE} stepMode_e;
    typedef enum logic [1:0] {GATE_NORM, GATE_TIE, GATE_REST, GATE_GLIDE} gate_e;
    typedef enum logic [2:0] {TGT_CURR, TGT_PROG_A, TGT_PROG_B, TGT_PERF_A,
                              TGT_ARP_MONO, TGT_ARP_POLY, TGT_ARP_USER} target_e;
    typedef enum logic [2:0] {MSG_NONE, MSG_NOTE_ON, MSG_NOTE_OFF, MSG_CTRL, MSG_PROG} msgKind_e;
    typedef enum logic [1:0] {EDIT_NOTE, EDIT_VEL, EDIT_GATE} editField_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        msgKind_e kind;
        logic [3:0] chan;
        logic [6:0] d1;
        logic [6:0] d2;
    } midiMsg_s;

    typedef struct packed {
        target_e target;
        logic [6:0] number;
    } mapEntry_s;

    typedef struct packed {
        gate_e gate;
        logic [6:0] note;
        logic [6:0] vel;
    } step_s;

    typedef struct packed {
        logic valid;
        logic [6:0] idx;
        mapEntry_s entry;
    } mapEdit_s;

    typedef struct packed {
        logic valid;
        editField_e field;
        logic [6:0] value;
    } stepEdit_s;

    typedef struct packed {
        logic valid;
        logic [3:0] part;
        logic viaMap;
        logic assignPattern;
        logic [6:0] bank;
        mapEntry_s entry;
    } loadReq_s;

    typedef struct packed {
        logic valid;
        logic [6:0] pattern;
        logic poly;
        logic [6:0] count;
    } patStore_s;

endpackage : midi_map_pkg

// ---- verilog/midi_program_map_and_step_entry.sv ----
/*
 * Program change filter, per-part bank state, program map and MIDI step entry
 * into a 64-step user pattern edit buffer.
 * Assumes one parsed MIDI message per cycle on the same clock; pattern storage
 * itself lies outside and takes the store pulse.
 */
`timescale 1ns/10ps

// Overview of operation
// R01 - Program change filter has three settings: enabled, forced map, disabled.
// R02 - Enabled: bank 0 routes through the map, other banks address directly.
// R03 - Forced map: every program change uses the map; bank selects still update the part's bank state.
// R04 - Disabled: drop program changes and both bank select controllers.
// R05 - Controller 32 value 0 makes later program changes for that part mapped.
// R06 - After reset every part uses the map until a bank select arrives.
// R07 - A part keeps its selected bank until its next bank select.
// R08 - Map holds 128 entries of target class plus number.
// R09 - Mapped change loads the entry; pattern targets assign to current program.
// R10 - Write commands commit map or pattern edits only with protect off.
// R11 - Step entry mode off, full, note, velocity or gate; off writes nothing from the keyboard.
// R12 - Note on stores note and velocity; matching note off advances step.
// R13 - Pedal pressed with no note writes rest; pedal release advances.
// R14 - Note played under rest pedal writes tie; its release advances.
// R15 - Pedal pressed while note held writes glide; note release advances.
// R16 - Step entry accepts notes and pedal on any channel.
// R17 - 128 user patterns; up to 63 mono, 64 to 127 poly.
// R18 - Step count 1 to 64 limits the editable step index.
// R19 - Each step holds gate type normal, tie, rest or glide.
// R20 - Note range 1 to 12 mono, minus 36 to plus 36 poly.
// R21 - Velocity ranges 1 to 127 and is stored with the step.
// R22 - Note and velocity edits only on normal or glide steps; keyboard note and velocity modes write them on any step.
// R23 - Memory protect on refuses every store; off allows it.
module midi_program_map_and_step_entry
    import midi_map_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire midiMsg_s midiIn,
    input wire pcFilter_e pcFilter,
    input wire stepMode_e stepMode,
    input wire logic memProtect,
    input wire logic [6:0] patternSel,
    input wire logic [6:0] stepCount,
    input wire logic stepSelValid,
    input wire logic [5:0] stepSelIdx,
    input wire stepEdit_s stepEdit,
    input wire mapEdit_s mapEdit,
    input wire logic mapWriteCmd,
    input wire logic patternWriteCmd,
    output loadReq_s loadReq,
    output logic [5:0] curStep,
    output step_s stepView,
    output patStore_s patternStore,
    output logic mapStored
);

    // ==========================================================
    // state
    typedef struct packed {
        mapEntry_s [127:0] map;
        logic [15:0] mapped;
        logic [15:0][6:0] bank;
        step_s [63:0] steps;
        logic [5:0] ptr;
        logic noteHeld;
        logic sustain;
        logic restArmed;
        logic [6:0] heldNote;
        mapEdit_s pend;
        loadReq_s load;
        patStore_s store;
        logic mapDone;
    } state_s;

    state_s q;
    state_s d;

    // ==========================================================
    // helpers
    // clamp a signed note to the pattern type's range
    function automatic logic [6:0] fitNote(input logic poly, input logic signed [7:0] v);
        logic signed [7:0] r;
        if (poly)
            r = (v > POLY_NOTE_MAX) ? POLY_NOTE_MAX : ((v < POLY_NOTE_MIN) ? POLY_NOTE_MIN : v);
        else
            r = (v > MONO_NOTE_MAX) ? MONO_NOTE_MAX : ((v < MONO_NOTE_MIN) ? MONO_NOTE_MIN : v);
        return r[6:0];
    endfunction : fitNote

    // keyboard key to step note value
    function automatic logic [6:0] keyNote(input logic poly, input logic [6:0] key);
        logic [6:0] m;
        m = key % KEYS_PER_OCTAVE;
        if (poly)
            return fitNote(1'b1, signed'({1'b0, key} - NOTE_REF));
        return fitNote(1'b0, signed'({1'b0, m} + 8'h01));
    endfunction : keyNote

    // velocity zero is not a stored value
    function automatic logic [6:0] fitVel(input logic [6:0] v);
        return (v == 7'h00) ? VEL_MIN : v;
    endfunction : fitVel

    // last valid step index for a step count
    function automatic logic [5:0] stepLast(input logic [6:0] cnt);
        if (cnt < STEP_COUNT_MIN)
            return PTR_RST;
        if (cnt > STEP_COUNT_MAX)
            return STEP_LAST_MAX;
        return 6'(cnt - STEP_COUNT_MIN);
    endfunction : stepLast

    // advance with wrap at the pattern end
    function automatic logic [5:0] nextStep(input logic [5:0] p, input logic [5:0] last);
        return (p >= last) ? PTR_RST : 6'(p + 6'h01);
    endfunction : nextStep

    // write the fields that the entry mode allows
    function automatic step_s putStep(input step_s s, input stepMode_e m, input gate_e g,
                                      input logic [6:0] n, input logic [6:0] v, input logic nv);
        step_s r;
        r = s;
        if (m == STEP_FULL || m == STEP_GATE)
            r.gate = g;
        if (nv && (m == STEP_FULL || m == STEP_NOTE))
            r.note = n;
        if (nv && (m == STEP_FULL || m == STEP_VEL))
            r.vel = v;
        return r;
    endfunction : putStep

    // ==========================================================
    // message decode
    logic isProg;
    logic isBankLsb;
    logic isPedal;
    logic pedalDown;
    logic isNoteOn;
    logic isNoteOff;
    logic poly;
    logic viaMap;
    logic [5:0] last;

    assign isProg = midiIn.kind == MSG_PROG;
    assign isBankLsb = midiIn.kind == MSG_CTRL && midiIn.d1 == CC_BANK_LSB;
    assign isPedal = midiIn.kind == MSG_CTRL && midiIn.d1 == CC_SUSTAIN;
    assign pedalDown = midiIn.d2 >= SUSTAIN_ON_MIN;
    assign isNoteOn = midiIn.kind == MSG_NOTE_ON && midiIn.d2 != 7'h00;
    assign isNoteOff = midiIn.kind == MSG_NOTE_OFF || (midiIn.kind == MSG_NOTE_ON && midiIn.d2 == 7'h00);
    assign poly = patternSel > MONO_LAST; // R17
    assign last = stepLast(stepCount); // R18
    assign viaMap = pcFilter == PC_FORCE_MAP || q.mapped[midiIn.chan]; // R02 R03

    // ==========================================================
    // next state
    always_comb
    begin
        d = q;
        d.load.valid = 1'b0;
        d.store.valid = 1'b0;
        d.mapDone = 1'b0;

        // bank select per part; controller 0 carries nothing here
        if (isBankLsb && pcFilter != PC_DISABLED) // R04
        begin
            d.bank[midiIn.chan] = midiIn.d2; // R07
            d.mapped[midiIn.chan] = midiIn.d2 == MAP_BANK; // R05
        end

        // program change resolution
        if (isProg && pcFilter != PC_DISABLED) // R01 R04
        begin
            d.load.valid = 1'b1;
            d.load.part = midiIn.chan;
            d.load.viaMap = viaMap;
            d.load.bank = q.bank[midiIn.chan];
            d.load.entry = viaMap ? q.map[midiIn.d1] : mapEntry_s'{target: TGT_CURR, number: midiIn.d1}; // R08 R02
            d.load.assignPattern = viaMap && q.map[midiIn.d1].target >= TGT_ARP_MONO; // R09
        end

        // map edits held until committed
        if (mapEdit.valid)
            d.pend = mapEdit;
        if (mapWriteCmd && !memProtect) // R10 R23
        begin
            d.map[q.pend.idx] = q.pend.entry;
            d.mapDone = 1'b1;
        end

        // keyboard step entry, any channel
        if (stepMode != STEP_OFF) // R11 R16
        begin
            if (isNoteOn && !q.noteHeld)
            begin
                d.noteHeld = 1'b1;
                d.heldNote = midiIn.d1;
                if (q.sustain && q.restArmed)
                begin
                    d.steps[q.ptr] = putStep(q.steps[q.ptr], stepMode, GATE_TIE, 7'h00, 7'h00, 1'b0); // R14
                    d.restArmed = 1'b0;
                end
                else
                    d.steps[q.ptr] = putStep(q.steps[q.ptr], stepMode, GATE_NORM,
                                             keyNote(poly, midiIn.d1), fitVel(midiIn.d2), 1'b1); // R12 R20 R21
            end
            if (isNoteOff && q.noteHeld && midiIn.d1 == q.heldNote)
            begin
                d.noteHeld = 1'b0;
                d.ptr = nextStep(q.ptr, last); // R12 R14 R15
            end
            if (isPedal && pedalDown && !q.sustain)
            begin
                d.sustain = 1'b1;
                d.restArmed = !q.noteHeld;
                d.steps[q.ptr] = putStep(q.steps[q.ptr], stepMode, q.noteHeld ? GATE_GLIDE : GATE_REST,
                                         7'h00, 7'h00, 1'b0); // R13 R15
            end
            if (isPedal && !pedalDown && q.sustain)
            begin
                d.sustain = 1'b0;
                d.restArmed = 1'b0;
                if (q.restArmed)
                    d.ptr = nextStep(q.ptr, last); // R13
            end
        end
        else
        begin
            d.noteHeld = 1'b0;
            d.sustain = 1'b0;
            d.restArmed = 1'b0;
        end

        // panel step select and field edits
        if (stepSelValid)
            d.ptr = stepSelIdx;
        if (stepEdit.valid)
        begin
            case (stepEdit.field)
                EDIT_GATE: d.steps[q.ptr].gate = gate_e'(stepEdit.value[1:0]); // R19
                EDIT_NOTE:
                    if (q.steps[q.ptr].gate == GATE_NORM || q.steps[q.ptr].gate == GATE_GLIDE) // R22
                        // mono values are plain, poly values are two's complement
                        d.steps[q.ptr].note = fitNote(poly,
                            signed'({poly & stepEdit.value[6], stepEdit.value})); // R20
                EDIT_VEL:
                    if (q.steps[q.ptr].gate == GATE_NORM || q.steps[q.ptr].gate == GATE_GLIDE) // R22
                        d.steps[q.ptr].vel = fitVel(stepEdit.value); // R21
                default: d.steps[q.ptr] = q.steps[q.ptr];
            endcase
        end

        // keep the pointer inside the pattern length
        if (d.ptr > last) // R18
            d.ptr = last;

        // pattern store request
        if (patternWriteCmd && !memProtect) // R10 R23
        begin
            d.store.valid = 1'b1;
            d.store.pattern = patternSel;
            d.store.poly = poly;
            d.store.count = 7'({1'b0, last} + 7'h01);
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
            q.mapped <= '1; // R06
        end
        else
            q <= d;
    end

    // ==========================================================
    // outputs
    assign loadReq = q.load;
    assign curStep = q.ptr;
    assign stepView = q.steps[q.ptr];
    assign patternStore = q.store;
    assign mapStored = q.mapDone;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence mapBankSel;
        isBankLsb && midiIn.d2 == MAP_BANK && pcFilter == PC_ENABLED;
    endsequence

    sequence progSamePart;
        isProg && pcFilter == PC_ENABLED && midiIn.chan == $past(midiIn.chan, 2);
    endsequence

    sequence restPress;
        stepMode == STEP_FULL && isPedal && pedalDown && !q.sustain && !q.noteHeld
            && !stepEdit.valid && !stepSelValid;
    endsequence

    sequence glidePress;
        stepMode == STEP_FULL && isPedal && pedalDown && !q.sustain && q.noteHeld
            && !stepEdit.valid && !stepSelValid;
    endsequence

    AST_DISABLED_NO_LOAD: assert property ((pcFilter == PC_DISABLED) |=> !loadReq.valid) // R04
        else $error("load issued while filter disabled");

    AST_DISABLED_KEEPS_BANK: assert property (isBankLsb && pcFilter == PC_DISABLED // R04
        |=> $stable(q.bank) && $stable(q.mapped))
        else $error("bank select taken while filter disabled");

    AST_FORCED_VIA_MAP: assert property (isProg && pcFilter == PC_FORCE_MAP // R03
        |=> loadReq.valid && loadReq.viaMap)
        else $error("forced map not used");

    AST_MAP_SELECT: assert property (mapBankSel ##1 !isBankLsb ##1 progSamePart |=> loadReq.viaMap) // R05
        else $error("bank 0 did not select the map");

    AST_OFF_NO_ENTRY: assert property (stepMode == STEP_OFF && !stepEdit.valid |=> $stable(q.steps)) // R11
        else $error("step written with entry off");

    AST_NOTEOFF_ADVANCE: assert property (stepMode != STEP_OFF && isNoteOff && q.noteHeld // R12
        && midiIn.d1 == q.heldNote && !stepSelValid |=> curStep == nextStep($past(q.ptr), $past(last)))
        else $error("note off did not advance");

    AST_PEDAL_REST: assert property (restPress |=> stepView.gate == GATE_REST ##0 q.restArmed) // R13
        else $error("rest not written on pedal");

    AST_PROTECT_NO_STORE: assert property (memProtect |=> !patternStore.valid && !mapStored) // R23 R10
        else $error("store issued under protect");

    AST_MAP_COMMIT: assert property (mapWriteCmd && !memProtect // R10
        |=> mapStored && q.map[$past(q.pend.idx)] == $past(q.pend.entry))
        else $error("map edit not committed");

    AST_STORE_PULSE: assert property (patternWriteCmd && !memProtect // R10
        |=> patternStore.valid && patternStore.pattern == $past(patternSel))
        else $error("pattern store not issued");

    AST_PEDAL_GLIDE: assert property (glidePress |=> stepView.gate == GATE_GLIDE) // R15
        else $error("glide not written on pedal");

    AST_PTR_RANGE: assert property (##1 $stable(stepCount) |-> curStep <= last) // R18
        else $error("step index beyond pattern length");

endmodule : midi_program_map_and_step_entry
